/* sdct_ctrl.sv */
// host-side command timing controller for a two-bank sdram
`timescale 1ns/100ps
`default_nettype none
module sdct_ctrl
  import sdct_pkg::*;
#(
  parameter int INIT_CYC  = C_INIT,
  parameter int REFI_CYC  = C_REFI,
  parameter int RASX_CYC  = C_RASX,
  parameter logic [11:0] MODE_VAL = 12'h0_030
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // user command port
  input  wire logic        req_i,
  input  wire logic [3:0]  req_cmd_i,
  input  wire logic [11:0] req_addr_i,
  input  wire logic [3:0]  req_burst_i,
  output logic             req_ready_o,
  output logic             init_done_o,
  // sdram pins
  output logic             cke_o,
  output logic [3:0]       cmd_o,
  output logic [11:0]      addr_o
);
  if (INIT_CYC < 1 || REFI_CYC < C_RC || RASX_CYC <= C_RAS) begin
    $error("sdct_ctrl: timing parameters out of range");
  end

  sdct_state_e state;
  logic [31:0] wait_cnt;
  logic [3:0]  iref_cnt;
  logic [31:0] refi_cnt;
  logic        ref_due;
  logic [7:0]  rc_cnt;
  logic [7:0]  rrd_cnt;
  logic [7:0]  ras_cnt [2];
  logic [7:0]  rp_cnt  [2];
  logic [7:0]  rcd_cnt [2];
  logic [7:0]  dpl_cnt [2];
  logic [31:0] open_cnt [2];
  logic [1:0]  open;
  logic [3:0]  wr_left;
  logic        wr_bank;
  logic        wr_auto;
  logic        last_bank;
  logic        issue;
  logic [3:0]  icmd;
  logic [11:0] iaddr;
  logic        ibank;
  logic        force_pre;

  // refresh or an overdue row preempts user traffic
  always_comb begin
    force_pre = (open[0] && open_cnt[0] >= RASX_CYC[31:0]) ||
                (open[1] && open_cnt[1] >= RASX_CYC[31:0]);
  end

  // user commands are legal only when the counters that guard that command have expired
  always_comb begin
    icmd  = req_cmd_i;
    iaddr = req_addr_i;
    ibank = req_addr_i[BS_BIT];
    issue = 1'b0;
    if (state == ST_IDLE && req_i && !ref_due && !force_pre &&
        wr_left == 4'h0) begin
      unique case (req_cmd_i)
        CMD_ACT: issue = !open[ibank] && rc_cnt == 8'h00 &&
                         rp_cnt[ibank] == 8'h00 &&
                         (rrd_cnt == 8'h00 || last_bank == ibank) &&
                         dpl_cnt[ibank] == 8'h00;
        CMD_RD, CMD_WR: issue = open[ibank] &&
                                rcd_cnt[ibank] == 8'h00;
        CMD_PRE: issue = (req_addr_i[AB_BIT] ?
                          (ras_cnt[0] == 8'h00 && ras_cnt[1] == 8'h00 &&
                           dpl_cnt[0] == 8'h00 && dpl_cnt[1] == 8'h00) :
                          (ras_cnt[ibank] == 8'h00 &&
                           dpl_cnt[ibank] == 8'h00));
        default: issue = 1'b0;
      endcase
    end
  end

  // sequencer for power-on, refresh and forced close
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state       <= ST_POWER;
      wait_cnt    <= 32'h0000_0000;
      iref_cnt    <= 4'h0;
      cke_o       <= 1'b0;
      cmd_o       <= CMD_NOP;
      addr_o      <= 12'h0_000;
      init_done_o <= 1'b0;
      req_ready_o <= 1'b0;
    end else begin
      cmd_o       <= CMD_NOP;
      req_ready_o <= 1'b0;
      if (wait_cnt != 32'h0000_0000) begin
        wait_cnt <= wait_cnt - 32'h0000_0001;
      end
      unique case (state)
        ST_POWER: if (wait_cnt == 32'h0000_0000 && !cke_o) begin
          wait_cnt <= INIT_CYC[31:0];
          cke_o    <= 1'b1;
          state    <= ST_CKE;
        end
        ST_CKE: if (wait_cnt == 32'h0000_0000) begin
          wait_cnt <= C_CKA[31:0];
          state    <= ST_PALL;
        end
        ST_PALL: if (wait_cnt == 32'h0000_0000) begin
          cmd_o            <= CMD_PRE;
          addr_o           <= 12'h0_000;
          addr_o[AB_BIT]   <= 1'b1;
          wait_cnt         <= C_RP[31:0];
          state            <= ST_IREF;
        end
        ST_IREF: if (wait_cnt == 32'h0000_0000) begin
          if (iref_cnt == INIT_REFS[3:0]) begin
            state <= ST_MRS;
          end else begin
            cmd_o    <= CMD_REF;
            iref_cnt <= iref_cnt + 4'h1;
            wait_cnt <= C_RC[31:0];
          end
        end
        ST_MRS: begin
          cmd_o    <= CMD_MRS;
          addr_o   <= MODE_VAL;
          wait_cnt <= T_MCD_CLK[31:0];
          state    <= ST_DONE;
        end
        ST_DONE: if (wait_cnt == 32'h0000_0000) begin
          init_done_o <= 1'b1;
          state       <= ST_IDLE;
        end
        // spacing counters load one edge after a command reaches the pins,
        // so that edge never issues another command on stale counters
        ST_IDLE: if (cmd_o == CMD_NOP) begin
          if (ref_due || force_pre) begin
            if (open != 2'b00) begin
              if (ras_cnt[0] == 8'h00 && ras_cnt[1] == 8'h00 &&
                  dpl_cnt[0] == 8'h00 && dpl_cnt[1] == 8'h00 &&
                  wr_left == 4'h0) begin
                cmd_o          <= CMD_PRE;
                addr_o         <= 12'h0_000;
                addr_o[AB_BIT] <= 1'b1;
              end
            end else if (ref_due && rc_cnt == 8'h00 &&
                         rp_cnt[0] == 8'h00 && rp_cnt[1] == 8'h00 &&
                         dpl_cnt[0] == 8'h00 && dpl_cnt[1] == 8'h00) begin
              cmd_o <= CMD_REF;
              state <= ST_WAIT;
            end
          end else if (issue) begin
            cmd_o       <= icmd;
            addr_o      <= iaddr;
            req_ready_o <= 1'b1;
          end
        end
        ST_WAIT: state <= ST_IDLE;
        default: state <= ST_POWER;
      endcase
    end
  end

  // refresh interval timer; a due refresh waits but is never dropped
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      refi_cnt <= 32'h0000_0000;
      ref_due  <= 1'b0;
    end else begin
      if (state == ST_WAIT) begin
        ref_due <= 1'b0;
      end
      if (init_done_o) begin
        if (refi_cnt >= REFI_CYC[31:0] - 32'h0000_0001) begin
          refi_cnt <= 32'h0000_0000;
          ref_due  <= 1'b1;
        end else begin
          refi_cnt <= refi_cnt + 32'h0000_0001;
        end
      end
    end
  end

  // spacing counters, loaded from the command actually driven on the pins
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rc_cnt    <= 8'h00;
      rrd_cnt   <= 8'h00;
      last_bank <= 1'b0;
      open      <= 2'b00;
      wr_left   <= 4'h0;
      wr_bank   <= 1'b0;
      wr_auto   <= 1'b0;
      for (int b = 0; b < 2; b++) begin
        ras_cnt[b]  <= 8'h00;
        rp_cnt[b]   <= 8'h00;
        rcd_cnt[b]  <= 8'h00;
        dpl_cnt[b]  <= 8'h00;
        open_cnt[b] <= 32'h0000_0000;
      end
    end else begin
      if (rc_cnt != 8'h00) rc_cnt <= rc_cnt - 8'h01;
      if (rrd_cnt != 8'h00) rrd_cnt <= rrd_cnt - 8'h01;
      for (int b = 0; b < 2; b++) begin
        if (ras_cnt[b] != 8'h00) ras_cnt[b] <= ras_cnt[b] - 8'h01;
        if (rp_cnt[b] != 8'h00) rp_cnt[b] <= rp_cnt[b] - 8'h01;
        if (rcd_cnt[b] != 8'h00) rcd_cnt[b] <= rcd_cnt[b] - 8'h01;
        if (dpl_cnt[b] != 8'h00) dpl_cnt[b] <= dpl_cnt[b] - 8'h01;
        open_cnt[b] <= open[b] ? open_cnt[b] + 32'h0000_0001 : 32'h0000_0000;
      end
      // last write beat: start recovery, auto-precharge closes the bank
      if (wr_left != 4'h0) begin
        wr_left <= wr_left - 4'h1;
        if (wr_left == 4'h1) begin
          if (wr_auto) begin
            dpl_cnt[wr_bank] <= C_DAL[7:0];
            open[wr_bank]    <= 1'b0;
          end else begin
            dpl_cnt[wr_bank] <= T_DPL_CLK[7:0];
          end
        end
      end
      unique case (cmd_o)
        CMD_ACT: begin
          rc_cnt                  <= C_RC[7:0] - 8'h01;
          rrd_cnt                 <= C_RRD[7:0] - 8'h01;
          last_bank               <= addr_o[BS_BIT];
          ras_cnt[addr_o[BS_BIT]] <= C_RAS[7:0] - 8'h01;
          rcd_cnt[addr_o[BS_BIT]] <= C_RCD[7:0] - 8'h01;
          open[addr_o[BS_BIT]]    <= 1'b1;
        end
        CMD_REF: rc_cnt <= C_RC[7:0] - 8'h01;
        CMD_PRE: begin
          for (int b = 0; b < 2; b++) begin
            if (addr_o[AB_BIT] || addr_o[BS_BIT] == b[0]) begin
              rp_cnt[b] <= C_RP[7:0] - 8'h01;
              open[b]   <= 1'b0;
            end
          end
        end
        CMD_WR: begin
          // burst length 0 still counts one data beat
          wr_left <= (req_burst_i == 4'h0) ? 4'h1 : req_burst_i;
          wr_bank <= addr_o[BS_BIT];
          wr_auto <= addr_o[AB_BIT];
        end
        CMD_RD: if (addr_o[AB_BIT]) begin
          rp_cnt[addr_o[BS_BIT]] <= C_RP[7:0] + {4'h0, req_burst_i};
          open[addr_o[BS_BIT]]   <= 1'b0;
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

/* sdct_pkg.sv */
// constants and types for the sdram command-timing controller
// Functional notes
// - space activate/refresh pairs by at least the row cycle time (48/54/63 ns).
// - precharge no sooner than 32/36/42 ns after activate; row open at most 100 us.
// - wait 16/18/20 ns after precharge before activating that bank again.
// - read or write no sooner than 16 ns after its bank's activate.
// - activates to different banks are at least 11/12/14 ns apart.
// - two clocks after last write data before a precharge.
// - auto-precharge write: two clocks plus precharge time before activate/refresh.
// - issue 2048 refreshes within every 32 ms.
// - after raising clock enable, wait one clock plus 3 ns before commands.
// - wait 100 us after power is stable before any memory operation.
// - finish initialization before any read, write or refresh traffic; the code issues INIT_REFS refreshes before init_done_o.
// - wait two clocks after loading the mode register.
// - all-banks bit high precharges both banks, low only the selected bank.
`default_nettype none
package sdct_pkg;
  localparam int CLK_PS      = 8000;
  localparam int T_RC_PS     = 48000;
  localparam int T_RAS_PS    = 32000;
  localparam int T_RAS_MAX_PS = 100000000;
  localparam int T_RP_PS     = 16000;
  localparam int T_RCD_PS    = 16000;
  localparam int T_RRD_PS    = 11000;
  localparam int T_CKA_PS    = 3000;
  localparam int T_INIT_US   = 100;
  localparam int T_REF_MS    = 32;
  localparam int REF_ROWS    = 2048;
  localparam int T_DPL_CLK   = 2;
  localparam int T_MCD_CLK   = 2;
  localparam int INIT_REFS   = 2;
  // round up the minima, round down the maxima
  localparam int C_RC   = (T_RC_PS + CLK_PS - 1) / CLK_PS;
  localparam int C_RAS  = (T_RAS_PS + CLK_PS - 1) / CLK_PS;
  localparam int C_RASX = T_RAS_MAX_PS / CLK_PS;
  localparam int C_RP   = (T_RP_PS + CLK_PS - 1) / CLK_PS;
  localparam int C_RCD  = (T_RCD_PS + CLK_PS - 1) / CLK_PS;
  localparam int C_RRD  = (T_RRD_PS + CLK_PS - 1) / CLK_PS;
  localparam int C_CKA  = 1 + (T_CKA_PS + CLK_PS - 1) / CLK_PS;
  localparam int C_DAL  = T_DPL_CLK + C_RP;
  localparam int C_INIT = T_INIT_US * 1000000 / CLK_PS;
  // ms to cycles in two steps so no product leaves the 32-bit int range
  localparam int C_REFI = T_REF_MS * 1000000 / CLK_PS * 1000 / REF_ROWS;
  // command pins {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam int AB_BIT = 10;
  localparam int BS_BIT = 11;
  typedef enum logic [7:0] {
    ST_POWER = 8'h01, ST_CKE  = 8'h02, ST_PALL = 8'h04, ST_IREF = 8'h08,
    ST_MRS   = 8'h10, ST_IDLE = 8'h20, ST_WAIT = 8'h40, ST_DONE = 8'h80
  } sdct_state_e;
endpackage
`default_nettype wire

/* sdct_ctrl_assertions.sv */
// concurrent checks on the sdram pins of the command timing controller
`timescale 1ns/100ps
`default_nettype none
module sdct_ctrl_assertions
  import sdct_pkg::*;
#(
  parameter int INIT_CYC = C_INIT,
  parameter int REFI_CYC = C_REFI
) (
  // clock, reset and pins watched
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        init_done_o,
  input wire logic        cke_o,
  input wire logic [3:0]  cmd_o,
  input wire logic [11:0] addr_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic [7:0]  act_age [2];
  logic [7:0]  pre_age [2];
  logic [15:0] up;
  logic [15:0] since_ref;
  logic        act;
  logic        pre;
  logic        bnk;
  assign act = cmd_o == CMD_ACT;
  assign pre = cmd_o == CMD_PRE;
  assign bnk = addr_o[BS_BIT];
  // ages saturate so an idle bank never looks recently used
  always_ff @(posedge mclk_i or posedge rst_i) begin
    for (int b = 0; b < 2; b++) begin
      if (rst_i) begin
        act_age[b] <= 8'hff;
        pre_age[b] <= 8'hff;
      end else begin
        if (act && bnk == b[0]) act_age[b] <= 8'h00;
        else if (act_age[b] != 8'hff) act_age[b] <= act_age[b] + 8'h01;
        if (pre && (addr_o[AB_BIT] || bnk == b[0])) pre_age[b] <= 8'h00;
        else if (pre_age[b] != 8'hff) pre_age[b] <= pre_age[b] + 8'h01;
      end
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) up <= 16'h0000;
    else if (up != 16'hffff) up <= up + 16'h0001;
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) since_ref <= 16'h0000;
    else if (cmd_o == CMD_REF || !init_done_o) since_ref <= 16'h0000;
    else since_ref <= since_ref + 16'h0001;
  end
  a_row_cycle: assert property (
    act |-> act_age[bnk] >= C_RC - 1) else $error("row cycle short");
  a_ras_min: assert property (
    pre |-> act_age[bnk] >= C_RAS - 1 &&
    (!addr_o[AB_BIT] || act_age[!bnk] >= C_RAS - 1))
    else $error("act to pre short");
  a_rp_min: assert property (
    act |-> pre_age[bnk] >= C_RP - 1) else $error("pre to act short");
  a_rcd_min: assert property (
    cmd_o == CMD_RD || cmd_o == CMD_WR |-> act_age[bnk] >= C_RCD - 1)
    else $error("act to column short");
  a_rrd_min: assert property (
    act |-> act_age[!bnk] >= C_RRD - 1) else $error("bank to bank short");
  a_ref_period: assert property (
    since_ref < 2 * REFI_CYC) else $error("refresh overdue");
  a_cke_recover: assert property (
    $rose(cke_o) |-> cmd_o == CMD_NOP ##1 cmd_o == CMD_NOP)
    else $error("command too soon after clock enable");
  a_power_wait: assert property (
    cmd_o != CMD_NOP |-> up >= INIT_CYC) else $error("power wait short");
  a_init_first: assert property (
    cmd_o == CMD_RD || cmd_o == CMD_WR |-> init_done_o)
    else $error("traffic before init");
  a_mode_gap: assert property (
    cmd_o == CMD_MRS |=> cmd_o == CMD_NOP) else $error("mode gap short");
  c_act: cover property (act && init_done_o);
  c_auto_wr: cover property (cmd_o == CMD_WR && addr_o[AB_BIT]);
  c_ref: cover property (cmd_o == CMD_REF && init_done_o);
endmodule
bind sdct_ctrl sdct_ctrl_assertions #(
  .INIT_CYC(INIT_CYC),
  .REFI_CYC(REFI_CYC)
) i_chk (
  .mclk_i(mclk_i),
  .rst_i(rst_i),
  .init_done_o(init_done_o),
  .cke_o(cke_o),
  .cmd_o(cmd_o),
  .addr_o(addr_o)
);
`default_nettype wire

/* sdct_mem_model.sv */
// behavioural two-bank sdram: open banks and refresh count
`timescale 1ns/100ps
`default_nettype none
module sdct_mem_model
  import sdct_pkg::*;
(
  // pins from the controller
  input  wire logic        mclk_i,
  input  wire logic        cke_i,
  input  wire logic [3:0]  cmd_i,
  input  wire logic [11:0] addr_i,
  // state seen by the bench
  output var logic [1:0]   open_o = 2'h0,
  output var logic [15:0]  refs_o = 16'h0000
);
  // commands are ignored while the clock enable is low
  always @(posedge mclk_i) begin
    if (cke_i && cmd_i == CMD_ACT) open_o[addr_i[BS_BIT]] <= 1'b1;
    if (cke_i && cmd_i == CMD_PRE && addr_i[AB_BIT]) open_o <= 2'h0;
    if (cke_i && cmd_i == CMD_PRE && !addr_i[AB_BIT]) begin
      open_o[addr_i[BS_BIT]] <= 1'b0;
    end
    if (cke_i && cmd_i == CMD_REF) refs_o <= refs_o + 16'h0001;
  end
endmodule
`default_nettype wire

/* sdct_ctrl_bench.sv */
// self-checking bench for the sdram command timing controller
`timescale 1ns/100ps
`default_nettype none
module sdct_ctrl_bench;
  import sdct_pkg::*;
  localparam int INIT_CYC = 10;
  localparam int REFI_CYC = 40;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        req_i = 1'b0;
  logic [3:0]  req_cmd_i = CMD_NOP;
  logic [11:0] req_addr_i = 12'h000;
  logic [3:0]  req_burst_i = 4'h1;
  logic        req_ready_o, init_done_o, cke_o;
  logic [3:0]  cmd_o;
  logic [11:0] addr_o;
  logic [1:0]  banks_open;
  logic [15:0] refs;
  int          fails = 0;
  int          comparisons = 0;
  int          cyc = 0;
  sdct_ctrl #(.INIT_CYC(INIT_CYC), .REFI_CYC(REFI_CYC), .RASX_CYC(30)) i_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i), .req_cmd_i(req_cmd_i),
    .req_addr_i(req_addr_i), .req_burst_i(req_burst_i),
    .req_ready_o(req_ready_o), .init_done_o(init_done_o), .cke_o(cke_o),
    .cmd_o(cmd_o), .addr_o(addr_o));
  sdct_mem_model i_mem (.mclk_i(mclk_i), .cke_i(cke_o), .cmd_i(cmd_o),
    .addr_i(addr_o), .open_o(banks_open), .refs_o(refs));
  initial forever #4 mclk_i = ~mclk_i;
  task automatic finish_test();
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // the whole run needs well under a thousand cycles
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails = fails + 1;
      finish_test();
    end
  end
  task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_ge(input int gap, input int min);
    comparisons++;
    if (gap < min) begin
      fails++;
      $display("[FAIL] %0t gap %h min %h", $time, gap, min);
    end
  endtask
  // request held until the edge that samples the ready pulse; the pins
  // are taken at that same edge, then the request is dropped
  task automatic send(input logic [3:0] c, input logic [11:0] a,
                      input logic [3:0] b, output int t);
    int n;
    @(posedge mclk_i);
    req_i <= 1'b1;
    req_cmd_i <= c;
    req_addr_i <= a;
    req_burst_i <= b;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 400);
    t = cyc;
    chk_eq(32'(cmd_o), 32'(c));
    chk_eq(32'(addr_o), 32'(a));
    req_i <= 1'b0;
    @(negedge mclk_i);
  endtask
  // start right after a refresh so none lands mid-sequence
  task automatic sync_ref();
    logic [15:0] r0;
    int n;
    r0 = refs;
    n = 0;
    while (refs === r0 && n < 200) begin
      @(negedge mclk_i);
      n++;
    end
    chk_eq(32'(n < 200), 32'h0000_0001);
  endtask
  task automatic t_init();
    int t;
    send(CMD_ACT, 12'h000, 4'h1, t);
    chk_ge(t - 20, INIT_CYC);
    chk_eq(32'(init_done_o), 32'h0000_0001);
    chk_eq(32'(cke_o), 32'h0000_0001);
    chk_eq(32'(refs), 32'(INIT_REFS));
  endtask
  task automatic t_read();
    int a0, a1, r, p, a2, x;
    sync_ref();
    send(CMD_ACT, 12'h005, 4'h1, a0);
    send(CMD_ACT, 12'h805, 4'h1, a1);
    chk_ge(a1 - a0, C_RRD);
    send(CMD_RD, 12'h010, 4'h1, r);
    chk_ge(r - a0, C_RCD);
    send(CMD_PRE, 12'h000, 4'h1, p);
    chk_ge(p - a0, C_RAS);
    chk_eq(32'(banks_open), 32'h0000_0002);
    send(CMD_ACT, 12'h007, 4'h1, a2);
    chk_ge(a2 - p, C_RP);
    chk_ge(a2 - a0, C_RC);
    send(CMD_PRE, 12'h400, 4'h1, x);
    chk_eq(32'(banks_open), 32'h0000_0000);
  endtask
  task automatic t_write();
    int a, w, p;
    sync_ref();
    send(CMD_ACT, 12'h800, 4'h1, a);
    send(CMD_WR, 12'h800, 4'h4, w);
    chk_ge(w - a, C_RCD);
    send(CMD_PRE, 12'h800, 4'h4, p);
    chk_ge(p - w, 4 + T_DPL_CLK);
    send(CMD_ACT, 12'h801, 4'h4, a);
    chk_ge(a - p, C_RP);
    send(CMD_WR, 12'hc00, 4'h3, w);
    send(CMD_ACT, 12'h802, 4'h3, a);
    chk_ge(a - w, 3 + T_DPL_CLK + C_RP);
  endtask
  task automatic t_refresh();
    logic [15:0] r0;
    r0 = refs;
    repeat (400) @(posedge mclk_i);
    @(negedge mclk_i);
    chk_ge(int'(refs - r0), 400 / REFI_CYC - 1);
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_init();
    t_read();
    t_write();
    t_refresh();
    finish_test();
  end
endmodule
`default_nettype wire
